// ==== common/sbd_pkg.sv ====
package sbd_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS     = 40;
   localparam int ACK_WR_NS  = 50;
   localparam int ACK_R0_NS  = 50;
   localparam int ACK_R1_NS  = 105;
   localparam int ACK_R2_NS  = 200;
   localparam int ACC_NS     = 200;
   localparam int REF_INT_NS = 14000;
   localparam int REF_CYC_NS = 350;

   // longest times round down, never below one cycle
   function automatic int cyc_dn(input int ns);
      return (ns < CLK_NS) ? 1 : ns / CLK_NS;
   endfunction

   localparam int ACK_WR_CYC  = cyc_dn(ACK_WR_NS);
   localparam int ACK_R0_CYC  = cyc_dn(ACK_R0_NS);
   localparam int ACK_R1_CYC  = cyc_dn(ACK_R1_NS);
   localparam int ACK_R2_CYC  = cyc_dn(ACK_R2_NS);
   localparam int ACC_CYC     = cyc_dn(ACC_NS);
   localparam int REF_INT_CYC = cyc_dn(REF_INT_NS);
   localparam int REF_CYC     = cyc_dn(REF_CYC_NS);
   localparam int REF_TMR_W   = 9;

   // ---------------------------------------------------------------
   // local register port
   // ---------------------------------------------------------------
   localparam int          REG_AW   = 4;
   localparam logic [3:0]  REG_CFG  = 4'h0;
   localparam logic [3:0]  REG_STAT = 4'h1;
   localparam logic [31:0] CFG_RST  = 32'h0;
   localparam logic [15:0] ERR_RST  = 16'h0;

   localparam int F_BLK   = 0;
   localparam int F_MB    = 4;
   localparam int F_STOP  = 8;
   localparam int F_CROSS = 9;
   localparam int F_LO32  = 10;
   localparam int F_HI64  = 11;
   localparam int F_RDLY  = 12;
   localparam int F_AACK  = 14;
   localparam int F_PINT  = 15;
   localparam int F_LVL   = 16;
   localparam int F_IO16  = 19;
   localparam int F_IO40  = 20;
   localparam int F_IOSW  = 21;

   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam logic [23:0] LO32_TOP = 24'h008000;
   localparam logic [7:0]  HI64_BLK = 8'h0f;
   localparam logic [3:0]  IO_LO_A  = 4'h0;
   localparam logic [3:0]  IO_LO_B  = 4'h4;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [23:0] adr;
      logic        bhe;
      logic [15:0] din;
      logic        mrd;
      logic        mwr;
      logic        iord;
   } sbd_bus_s;

   typedef struct packed {
      logic        refr;
      logic        rd;
      logic [1:0]  we;
      logic [22:0] addr;
      logic [17:0] wdata;
   } sbd_mem_s;

   typedef enum {ST_IDLE, ST_REF, ST_MRD, ST_MWR, ST_IOR, ST_HOLD}
      sbd_state_e;
endpackage

// ==== rtl/sbd_ctrl.sv ====
`timescale 1ns/1ns
// Operation
// - decode all 24 address bits
// - start on switch-set 64K boundary
// - 20-bit systems keep megabyte switch zero
// - stop option ends range at megabyte
// - cross option lets range wrap past top of address space
// - lock out low 32K, high 64K; code does so only when the range starts at address 0
// - byte swap odd bytes to low lane
// - store parity with every write
// - check parity on every read
// - latch row and byte, light LED
// - enabled parity error drives chosen interrupt
// - error register readable by I/O read
// - 32 I/O addresses, 8/16-bit decode
// - low byte 00-0F or 40-4F
// - read acknowledge after 50/105/200 ns; code gives 160/160/200 ns
// - write acknowledge after 50 ns; code gives 40 ns
// - optional advance acknowledge equals acknowledge
// - refresh every 14 us unaided
// - refresh cycle within 350 ns
// - access 200 ns, cycle 300 ns
module sbd_ctrl #(
   parameter int         MEM_LOG2 = 20,
   parameter int         MEM_LAT  = 2,
   parameter logic [7:0] IO_HI    = 8'h00
) (
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // system bus pins
   input  wire sbd_pkg::sbd_bus_s           bus_pin,
   output logic [15:0]                      bus_dout_ff,
   output logic                             bus_doe_ff,
   output logic                             xack_ff,
   output logic                             aack_ff,
   output logic [7:0]                       int_ff,
   output logic                             led_ff,
   // dram array
   output sbd_pkg::sbd_mem_s                mem_ff,
   input  wire logic [17:0]                 mem_rdata,
   // local register port
   input  wire logic [sbd_pkg::REG_AW-1:0]  reg_addr,
   input  wire logic [31:0]                 reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic [31:0]                      reg_rdata_ff
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   localparam int CAP_CYC = 1 + MEM_LAT;

   // data must be back inside the access time
   if (MEM_LOG2 < 17 || MEM_LOG2 > 24) begin : g_bad_size
      $error("MEM_LOG2 must lie in 17..24");
   end
   if (MEM_LAT < 1 || CAP_CYC + 1 > sbd_pkg::ACC_CYC) begin : g_bad_lat
      $error("MEM_LAT too large for the access time");
   end

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic par8(input logic [7:0] b);
      return ^b;
   endfunction

   function automatic logic [3:0] ack_n(input logic [1:0] sel);
      int n;
      n = (sel == 2'd0) ? sbd_pkg::ACK_R0_CYC :
          (sel == 2'd1) ? sbd_pkg::ACK_R1_CYC : sbd_pkg::ACK_R2_CYC;
      if (n < CAP_CYC + 1) n = CAP_CYC + 1;
      return 4'(n);
   endfunction

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   sbd_pkg::sbd_bus_s sync1_ff;
   sbd_pkg::sbd_bus_s bin_ff;

   // data is sampled with its command; the master holds both steady
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= '0;
         bin_ff   <= '0;
      end else begin
         sync1_ff <= bus_pin;
         bin_ff   <= sync1_ff;
      end
   end

   // ---------------------------------------------------------------
   // configuration register
   // ---------------------------------------------------------------
   logic [31:0] cfg_ff;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= sbd_pkg::CFG_RST;
      end else if (reg_wr && reg_addr == sbd_pkg::REG_CFG) begin
         cfg_ff <= reg_wdata;
      end
   end

   logic [3:0] blk_sw;
   logic [3:0] mb_sw;
   logic [1:0] rdly;
   logic [2:0] lvl;
   logic [3:0] io_sw;
   logic       stop_en;
   logic       cross_en;
   logic       lo32_en;
   logic       hi64_en;
   logic       aack_en;
   logic       pint_en;
   logic       io16_en;
   logic       io40_en;

   assign blk_sw   = cfg_ff[sbd_pkg::F_BLK +: 4];
   assign mb_sw    = cfg_ff[sbd_pkg::F_MB +: 4];
   assign rdly     = cfg_ff[sbd_pkg::F_RDLY +: 2];
   assign lvl      = cfg_ff[sbd_pkg::F_LVL +: 3];
   assign io_sw    = cfg_ff[sbd_pkg::F_IOSW +: 4];
   assign stop_en  = cfg_ff[sbd_pkg::F_STOP];
   assign cross_en = cfg_ff[sbd_pkg::F_CROSS];
   assign lo32_en  = cfg_ff[sbd_pkg::F_LO32];
   assign hi64_en  = cfg_ff[sbd_pkg::F_HI64];
   assign aack_en  = cfg_ff[sbd_pkg::F_AACK];
   assign pint_en  = cfg_ff[sbd_pkg::F_PINT];
   assign io16_en  = cfg_ff[sbd_pkg::F_IO16];
   assign io40_en  = cfg_ff[sbd_pkg::F_IO40];

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   logic [23:0] start_a;
   logic [23:0] offs;
   logic [24:0] size_b;
   logic        mem_hit;
   logic        io_hit;
   logic [7:0]  io_lo;

   assign start_a = {mb_sw, blk_sw, 16'h0};
   assign offs    = bin_ff.adr - start_a;
   assign size_b  = 25'(1) << MEM_LOG2;
   assign io_lo   = {io40_en ? sbd_pkg::IO_LO_B : sbd_pkg::IO_LO_A,
                     io_sw};

   always_comb begin
      mem_hit = {1'b0, offs} < size_b;
      // without crossing the range does not wrap past the top
      if (!cross_en && bin_ff.adr < start_a) mem_hit = 1'b0;
      // upper bits undriven by a 20-bit master read as zero
      if (stop_en && bin_ff.adr[23:20] != mb_sw) mem_hit = 1'b0;
      if (start_a == 24'h0 && lo32_en && bin_ff.adr < sbd_pkg::LO32_TOP)
         mem_hit = 1'b0;
      if (start_a == 24'h0 && hi64_en &&
          bin_ff.adr[23:16] == sbd_pkg::HI64_BLK)
         mem_hit = 1'b0;
   end

   assign io_hit = bin_ff.adr[7:0] == io_lo &&
                   (!io16_en || bin_ff.adr[15:8] == IO_HI);

   // ---------------------------------------------------------------
   // refresh timer
   // ---------------------------------------------------------------
   logic [sbd_pkg::REF_TMR_W-1:0] ref_tmr_ff;
   logic                          ref_pend_ff;
   sbd_pkg::sbd_state_e           st_ff;
   sbd_pkg::sbd_state_e           nxt_st;
   logic [3:0]                    cnt_ff;
   logic                          ref_go;
   logic                          ref_tick;

   assign ref_tick = ref_tmr_ff ==
                     sbd_pkg::REF_TMR_W'(sbd_pkg::REF_INT_CYC - 1);
   assign ref_go   = st_ff == sbd_pkg::ST_IDLE &&
                     nxt_st == sbd_pkg::ST_REF;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_tmr_ff <= '0;
      end else if (ref_tick) begin
         ref_tmr_ff <= '0;
      end else begin
         ref_tmr_ff <= ref_tmr_ff + 1'b1;
      end
   end

   // a new tick wins over the start of the previous refresh
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_pend_ff <= 1'b0;
      end else if (ref_tick) begin
         ref_pend_ff <= 1'b1;
      end else if (ref_go) begin
         ref_pend_ff <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   logic       cmd_any;
   logic [3:0] ack_at;

   assign cmd_any = bin_ff.mrd || bin_ff.mwr || bin_ff.iord;

   always_comb begin
      ack_at = 4'(sbd_pkg::ACK_WR_CYC);
      if (st_ff == sbd_pkg::ST_MRD) ack_at = ack_n(rdly);
   end

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         sbd_pkg::ST_IDLE: begin
            // refresh only starts between accesses, never cuts one
            if (ref_pend_ff)
               nxt_st = sbd_pkg::ST_REF;
            else if (bin_ff.mrd && mem_hit)
               nxt_st = sbd_pkg::ST_MRD;
            else if (bin_ff.mwr && mem_hit)
               nxt_st = sbd_pkg::ST_MWR;
            else if (bin_ff.iord && io_hit)
               nxt_st = sbd_pkg::ST_IOR;
         end
         sbd_pkg::ST_REF: begin
            if (cnt_ff == 4'(sbd_pkg::REF_CYC - 1))
               nxt_st = sbd_pkg::ST_IDLE;
         end
         sbd_pkg::ST_MRD, sbd_pkg::ST_MWR, sbd_pkg::ST_IOR: begin
            if (cnt_ff == ack_at - 4'd1)
               nxt_st = sbd_pkg::ST_HOLD;
         end
         sbd_pkg::ST_HOLD: begin
            if (!cmd_any) nxt_st = sbd_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_ff  <= sbd_pkg::ST_IDLE;
         cnt_ff <= 4'h0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= (nxt_st == st_ff) ? cnt_ff + 4'd1 : 4'h0;
      end
   end

   // acknowledge stands from the step into hold until the command drops
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         xack_ff <= 1'b0;
         aack_ff <= 1'b0;
      end else begin
         xack_ff <= nxt_st == sbd_pkg::ST_HOLD;
         aack_ff <= nxt_st == sbd_pkg::ST_HOLD && aack_en;
      end
   end

   // ---------------------------------------------------------------
   // array access
   // ---------------------------------------------------------------
   logic [7:0] wr_hi;
   logic [1:0] lanes_ff;
   logic       odd_ff;
   logic       cap;
   logic [1:0] perr;

   // an odd byte arrives on the low lane and goes to the high byte
   assign wr_hi = bin_ff.adr[0] ? bin_ff.din[7:0] : bin_ff.din[15:8];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mem_ff <= '0;
      end else begin
         mem_ff.refr <= ref_go;
         mem_ff.rd   <= 1'b0;
         mem_ff.we   <= 2'b00;
         if (st_ff == sbd_pkg::ST_IDLE) begin
            mem_ff.addr  <= offs[23:1];
            mem_ff.wdata <= {par8(wr_hi), par8(bin_ff.din[7:0]),
                             wr_hi, bin_ff.din[7:0]};
            if (nxt_st == sbd_pkg::ST_MRD) mem_ff.rd <= 1'b1;
            if (nxt_st == sbd_pkg::ST_MWR)
               mem_ff.we <= {bin_ff.adr[0] | bin_ff.bhe,
                             !bin_ff.adr[0]};
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lanes_ff <= 2'b00;
         odd_ff   <= 1'b0;
      end else if (st_ff == sbd_pkg::ST_IDLE) begin
         lanes_ff <= {bin_ff.adr[0] | bin_ff.bhe, !bin_ff.adr[0]};
         odd_ff   <= bin_ff.adr[0] && !bin_ff.bhe;
      end
   end

   // read data are back MEM_LAT + 1 cycles after the strobe
   assign cap  = st_ff == sbd_pkg::ST_MRD &&
                 cnt_ff == 4'(CAP_CYC);
   assign perr = lanes_ff & {par8(mem_rdata[15:8]) != mem_rdata[17],
                             par8(mem_rdata[7:0]) != mem_rdata[16]};

   // ---------------------------------------------------------------
   // error register, LED and interrupt
   // ---------------------------------------------------------------
   logic [15:0] err_loc_ff;
   logic        err_clr;

   assign err_clr = st_ff == sbd_pkg::ST_IOR && cnt_ff == 4'h0;

   // a new error wins over the clear that a register read makes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         led_ff     <= 1'b0;
         err_loc_ff <= sbd_pkg::ERR_RST;
      end else if (cap && perr != 2'b00 && (!led_ff || err_clr)) begin
         led_ff     <= 1'b1;
         err_loc_ff <= {perr, mem_ff.addr[MEM_LOG2-2 -: 14]};
      end else if (err_clr) begin
         led_ff     <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         int_ff <= 8'h00;
      end else begin
         int_ff <= (led_ff && pint_en) ? 8'(8'h01 << lvl) : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // bus data out
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_dout_ff <= 16'h0;
         bus_doe_ff  <= 1'b0;
      end else if (cap) begin
         bus_dout_ff <= odd_ff ? {2{mem_rdata[15:8]}}
                               : mem_rdata[15:0];
         bus_doe_ff  <= 1'b1;
      end else if (err_clr) begin
         bus_dout_ff <= err_loc_ff;
         bus_doe_ff  <= 1'b1;
      end else if (nxt_st == sbd_pkg::ST_IDLE) begin
         bus_doe_ff  <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= 32'h0;
      end else if (reg_rd && reg_addr == sbd_pkg::REG_CFG) begin
         reg_rdata_ff <= cfg_ff;
      end else if (reg_rd && reg_addr == sbd_pkg::REG_STAT) begin
         reg_rdata_ff <= {14'h0, ref_pend_ff, led_ff, err_loc_ff};
      end else begin
         reg_rdata_ff <= 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_ref_tick;
      ref_tick |=> ref_pend_ff;
   endproperty
   a_ref_tick: assert property (p_ref_tick)
      else $error("refresh tick did not post a request");

   property p_ref_len;
      $rose(st_ff == sbd_pkg::ST_REF) |->
         (st_ff == sbd_pkg::ST_REF)[*8] ##1 st_ff != sbd_pkg::ST_REF;
   endproperty
   a_ref_len: assert property (p_ref_len)
      else $error("refresh cycle length wrong");

   property p_wr_ack;
      $rose(st_ff == sbd_pkg::ST_MWR) |-> !xack_ff ##1 xack_ff;
   endproperty
   a_wr_ack: assert property (p_wr_ack)
      else $error("write acknowledge not one cycle after start");

   property p_rd_ack;
      $rose(st_ff == sbd_pkg::ST_MRD) && rdly == 2'd2 |->
         !xack_ff[*5] ##1 xack_ff;
   endproperty
   a_rd_ack: assert property (p_rd_ack)
      else $error("slow read acknowledge at wrong time");

   property p_ack_data;
      $rose(xack_ff) && $past(st_ff == sbd_pkg::ST_MRD) |-> bus_doe_ff;
   endproperty
   a_ack_data: assert property (p_ack_data)
      else $error("read acknowledged before data");

   property p_aack;
      aack_ff |-> xack_ff && aack_en;
   endproperty
   a_aack: assert property (p_aack)
      else $error("advance acknowledge differs from acknowledge");

   property p_wpar;
      mem_ff.we != 2'b00 |->
         mem_ff.wdata[16] == par8(mem_ff.wdata[7:0]) &&
         mem_ff.wdata[17] == par8(mem_ff.wdata[15:8]);
   endproperty
   a_wpar: assert property (p_wpar)
      else $error("stored parity wrong");

   property p_perr;
      cap && perr != 2'b00 && !led_ff |=> led_ff;
   endproperty
   a_perr: assert property (p_perr)
      else $error("parity error not latched");

   property p_int;
      int_ff != 8'h00 |-> $past(led_ff) && $past(pint_en);
   endproperty
   a_int: assert property (p_int)
      else $error("interrupt without enabled error");

   property p_swap;
      cap && odd_ff |=> bus_dout_ff[7:0] == $past(mem_rdata[15:8]);
   endproperty
   a_swap: assert property (p_swap)
      else $error("odd byte not swapped to low lane");

   property p_lock;
      $rose(st_ff == sbd_pkg::ST_MRD) && start_a == 24'h0 && lo32_en
         |-> $past(bin_ff.adr) >= sbd_pkg::LO32_TOP;
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked low block answered");

endmodule // sbd_ctrl

// ==== test/sbd_mem_model.sv ====
`timescale 1ns/1ns
module sbd_mem_model (
   // clock
   input  wire logic              core_clk,
   // array side of the controller
   input  wire sbd_pkg::sbd_mem_s mem_ff,
   input  wire logic              bad_par,
   output logic [17:0]            mem_rdata
);
   // ------
   // array
   // ------
   logic [17:0] arr [256];
   logic [17:0] q_ff = 18'h0;
   logic        rd_ff = 1'b0;
   logic        rd2_ff = 1'b0;
   logic [7:0]  a;

   assign a = mem_ff.addr[7:0];
   initial mem_rdata = 18'h0;

   always @(posedge core_clk) begin
      rd_ff <= mem_ff.rd;
      rd2_ff <= rd_ff;
      // bad_par flips the low lane parity to fake a failing cell
      if (mem_ff.rd)
         q_ff <= arr[a] ^ {1'b0, bad_par, 16'h0};
      // data stands only in the third cycle after the strobe; toggling
      // outside it exposes early or late capture
      mem_rdata <= rd2_ff ? q_ff : ~mem_rdata;
      if (mem_ff.we[0])
         {arr[a][16], arr[a][7:0]} <= {mem_ff.wdata[16], mem_ff.wdata[7:0]};
      if (mem_ff.we[1])
         {arr[a][17], arr[a][15:8]} <= {mem_ff.wdata[17], mem_ff.wdata[15:8]};
   end
endmodule // sbd_mem_model

// ==== test/test_system_bus_dram_board_control.sv ====
`timescale 1ns/1ns
module test_system_bus_dram_board_control;
   // --------
   // harness
   // --------
   localparam logic [2:0] RD = 3'b001;
   localparam logic [2:0] WR = 3'b010;
   localparam logic [2:0] IO = 3'b100;
   logic              core_clk = 1'b0;
   logic              rst = 1'b1;
   logic              bad_par = 1'b0;
   sbd_pkg::sbd_bus_s pin = '0;
   logic [3:0]        ra = 4'h0;
   logic [31:0]       rwd = 32'h0;
   logic              rwr = 1'b0;
   logic              rrd = 1'b0;
   logic [15:0]       dout;
   logic              doe, xack, aack, led;
   logic [7:0]        intl;
   sbd_pkg::sbd_mem_s mem;
   logic [17:0]       mrdata;
   logic [31:0]       rdat_w, rdat;
   logic [1:0]        lwe;
   logic [17:0]       lwd;
   logic [15:0]       bd;
   logic              ba;
   int                bc;
   int                mismatches = 0;
   int                check_count = 0;

   always #20 core_clk = ~core_clk;

   always @(posedge core_clk)
      if (mem.we !== 2'b00) begin
         lwe <= mem.we;
         lwd <= mem.wdata;
      end

   sbd_ctrl #(.MEM_LOG2(20), .MEM_LAT(2), .IO_HI(8'h00)) sbd_ctrl_i (
      .core_clk(core_clk), .rst(rst), .bus_pin(pin), .bus_dout_ff(dout),
      .bus_doe_ff(doe), .xack_ff(xack), .aack_ff(aack), .int_ff(intl),
      .led_ff(led), .mem_ff(mem), .mem_rdata(mrdata), .reg_addr(ra),
      .reg_wdata(rwd), .reg_wr(rwr), .reg_rd(rrd), .reg_rdata_ff(rdat_w));

   sbd_mem_model sbd_mem_model_i (.core_clk(core_clk), .mem_ff(mem),
      .bad_par(bad_par), .mem_rdata(mrdata));

   // ------
   // tasks
   // ------
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      ra <= a;
      rwd <= d;
      rwr <= 1'b1;
      @(posedge core_clk);
      rwr <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a);
      ra <= a;
      rrd <= 1'b1;
      @(posedge core_clk);
      rrd <= 1'b0;
      @(posedge core_clk);
      rdat = rdat_w;
   endtask

   // command held until acknowledge; a miss gives up after 40 cycles
   task automatic bus(input logic [2:0] k, input logic [23:0] a,
                      input logic b, input logic [15:0] d, input bit hit);
      pin <= {a, b, d, k[0], k[1], k[2]};
      bc = 0;
      do begin
         @(posedge core_clk);
         bc++;
      end while (xack !== 1'b1 && bc < 40);
      bd = dout;
      ba = aack;
      pin <= '0;
      for (int n = 0; n < 40 && xack !== 1'b0; n++)
         @(posedge core_clk);
      if ((hit && bc == 40) || xack !== 1'b0) begin
         mismatches++;
         $display("CHECK FAILED handshake exp done got stuck");
         print_verdict();
      end else begin
         repeat (2) @(posedge core_clk);
      end
   endtask

   task automatic wait_ref(output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (mem.refr !== 1'b1 && n < 400);
      if (mem.refr !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED refresh exp pulse got none");
         print_verdict();
      end
   endtask

   // ----------
   // scenarios
   // ----------
   task automatic t_reset;
      rreg(4'h1);
      chk("stat_rst", 0, rdat);
      wreg(4'h1, 32'hffffffff);
      rreg(4'h1);
      chk("stat_ro", 0, rdat);
      wreg(4'h7, 32'h1);
      rreg(4'h7);
      chk("unmapped", 0, rdat);
      wreg(4'h0, 32'h01ffffff);
      rreg(4'h0);
      chk("cfg", 32'h01ffffff, rdat);
      $display("test reset done");
   endtask

   task automatic t_word;
      int n;
      int bw;
      int br;
      wait_ref(n);
      wait_ref(n);
      chk("ref_gap", sbd_pkg::REF_INT_CYC, n);
      // let the refresh finish so no timed access waits behind it
      repeat (sbd_pkg::REF_CYC) @(posedge core_clk);
      wreg(4'h0, 32'h1);
      bus(WR, 24'h010004, 1'b1, 16'h5a01, 1'b1);
      bw = bc;
      chk("we", 2'b11, lwe);
      chk("wdata", 18'h15a01, lwd);
      for (int s = 0; s < 3; s++) begin
         wreg(4'h0, 32'h1 | (s << 12));
         bus(RD, 24'h010004, 1'b1, 16'h0, 1'b1);
         if (s == 0)
            br = bc;
         chk("rdata", 16'h5a01, bd);
         chk("rd_ack", br + ((s == 2) ? 1 : 0), bc);
         chk("aack_off", 0, ba);
      end
      chk("wr_ack", br - 3, bw);
      $display("test word done");
   endtask

   task automatic t_byte;
      wreg(4'h0, 32'h4001);
      bus(WR, 24'h010007, 1'b0, 16'h00c3, 1'b1);
      chk("we_odd", 2'b10, lwe);
      chk("wd_odd", 9'h0c3, {lwd[17], lwd[15:8]});
      bus(RD, 24'h010007, 1'b0, 16'h0, 1'b1);
      chk("rd_odd", 8'hc3, bd[7:0]);
      chk("aack_on", 1, ba);
      bus(RD, 24'h010004, 1'b0, 16'h0, 1'b1);
      chk("rd_even", 8'h01, bd[7:0]);
      $display("test byte done");
   endtask

   task automatic t_decode;
      bus(RD, 24'h110004, 1'b1, 16'h0, 1'b0);
      chk("miss_mb", 40, bc);
      bus(RD, 24'h00fffe, 1'b1, 16'h0, 1'b0);
      chk("miss_lo", 40, bc);
      wreg(4'h0, 32'h11);
      bus(RD, 24'h110004, 1'b1, 16'h0, 1'b1);
      chk("hit_mb", 16'h5a01, bd);
      wreg(4'h0, 32'hc00);
      bus(WR, 24'h000100, 1'b1, 16'h0, 1'b0);
      chk("lock_lo", 40, bc);
      bus(WR, 24'h0f0010, 1'b1, 16'h0, 1'b0);
      chk("lock_hi", 40, bc);
      bus(WR, 24'h008000, 1'b1, 16'h0, 1'b1);
      chk("open_lo", 1, bc < 40);
      bus(RD, 24'h008000, 1'b1, 16'h0, 1'b1);
      chk("open_rd", 16'h0000, bd);
      bus(WR, 24'h0effe0, 1'b1, 16'h0, 1'b1);
      chk("open_hi", 1, bc < 40);
      wreg(4'h0, 32'h10f);
      bus(RD, 24'h100004, 1'b1, 16'h0, 1'b0);
      chk("stop_miss", 40, bc);
      wreg(4'h0, 32'h00f);
      bus(RD, 24'h100004, 1'b1, 16'h0, 1'b1);
      chk("span_hit", 16'h5a01, bd);
      wreg(4'h0, 32'h2ff);
      bus(RD, 24'h000004, 1'b1, 16'h0, 1'b1);
      chk("cross_hit", 16'h5a01, bd);
      $display("test decode done");
   endtask

   task automatic t_parity;
      wreg(4'h0, 32'h00b38001);
      bad_par <= 1'b1;
      bus(RD, 24'h010004, 1'b1, 16'h0, 1'b1);
      bad_par <= 1'b0;
      chk("led", 1, led);
      chk("irq", 8'h08, intl);
      bus(IO, 24'h000046, 1'b0, 16'h0, 1'b0);
      chk("io_miss", 40, bc);
      bus(IO, 24'h000045, 1'b0, 16'h0, 1'b1);
      chk("err_lane", 2'b01, bd[15:14]);
      chk("led_clr", 0, led);
      wreg(4'h0, 32'h00b30001);
      bad_par <= 1'b1;
      bus(RD, 24'h010004, 1'b1, 16'h0, 1'b1);
      bad_par <= 1'b0;
      chk("led2", 1, led);
      chk("irq_off", 8'h00, intl);
      $display("test parity done");
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_word();
      t_byte();
      t_decode();
      t_parity();
      print_verdict();
   end
endmodule // test_system_bus_dram_board_control
